// File: logic/ecu_edge_capture_unit.sv
// Function
// - Each qualifying event copies all 16 timebase bits into the result pair at once.
// - Mode picks falling, rising, every fourth rising or every sixteenth rising edge.
// - Each capture sets the event flag; only a software write clears it.
// - A new capture overwrites an unread result; no overrun protection.
// - Edges are taken from the real pin level, so port writes can trigger.
// - Prescaler counter held clear when off or outside capture modes.
// - Any reset clears the prescaler counter.
// - Switching between capture prescales keeps the counter; early capture possible.
// - On instruction clock the timebase halts in sleep and resumes afterwards.
// - With external timebase clock, captures continue during sleep.
//
// The register addresses and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ecu_edge_capture_unit (
  // Clock, reset and clock enable
  input  wire logic        i_clock,
  input  wire logic        i_resetn,
  input  wire logic        i_clock_en,
  // Avalon-MM slave
  input  wire logic [5:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [3:0]  i_avs_byteenable,
  input  wire logic [31:0] i_avs_writedata,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  // Pins and system state
  input  wire logic        i_capture_pin,
  input  wire logic        i_timebase_ext_clock,
  input  wire logic        i_sleep,
  // Interrupt
  output logic             o_irq
);

  logic [3:0]  capture_control_reg;
  logic [1:0]  tb_ctrl_reg;
  logic [15:0] capture_result_reg;
  logic        capture_event_flag_reg;
  logic [1:0]  irq_status_reg;
  logic [1:0]  irq_mask_reg;
  logic [3:0]  prescale_reg;
  logic [1:0]  instr_div_reg;
  logic        unread_reg;
  logic        ack_reg;
  logic [31:0] readdata_reg;
  logic        pin_level;
  logic        pin_level_reg;
  logic        ext_level;
  logic        ext_level_reg;
  logic [15:0] timebase_count;
  logic        req;
  logic        wr_do;
  logic        rd_do;
  logic        wr_byte0;
  logic        in_capture_mode;
  logic        capture_allowed;
  logic        pin_rise;
  logic        pin_fall;
  logic        prescale_event;
  logic        capture_now;
  logic        instr_tick;
  logic        ext_rise;
  logic        tb_advance;
  logic        wr_capture_ctrl;
  logic        wr_tb_ctrl;
  logic        wr_irq_mask;
  logic        wr_count_low;
  logic        wr_count_high;
  logic        wr_flag_clear;
  logic        rd_result_high;
  logic        rd_irq_status;

  // Avalon handshake: one wait state, action on the edge with waitrequest low
  assign req               = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & ~ack_reg;
  assign wr_do             = i_avs_write & ack_reg & i_clock_en;
  assign rd_do             = i_avs_read & ack_reg & i_clock_en;
  assign wr_byte0          = wr_do & i_avs_byteenable[0];

  // Register strobes, decoded once so every user sees the same access
  assign wr_capture_ctrl   = wr_byte0 & (i_avs_address == ecu_pkg::ADDR_CAPTURE_CTRL);
  assign wr_tb_ctrl        = wr_byte0 & (i_avs_address == ecu_pkg::ADDR_TB_CTRL);
  assign wr_irq_mask       = wr_byte0 & (i_avs_address == ecu_pkg::ADDR_IRQ_MASK);
  assign wr_count_low      = wr_byte0 & (i_avs_address == ecu_pkg::ADDR_TB_COUNT_LOW);
  assign wr_count_high     = wr_byte0 & (i_avs_address == ecu_pkg::ADDR_TB_COUNT_HIGH);
  assign wr_flag_clear     = wr_byte0 & (i_avs_address == ecu_pkg::ADDR_FLAG) &
                             ~i_avs_writedata[ecu_pkg::FLAG_CAPTURE_BIT];
  assign rd_result_high    = rd_do & (i_avs_address == ecu_pkg::ADDR_RESULT_HIGH);
  assign rd_irq_status     = rd_do & (i_avs_address == ecu_pkg::ADDR_IRQ_STATUS);

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      ack_reg <= 1'b0;
    end else if (i_clock_en) begin
      ack_reg <= req & ~ack_reg;
    end
  end

  // Read data registered in the wait cycle, stable at the completing edge
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      readdata_reg <= 32'h00000000;
    end else if (i_clock_en && i_avs_read && !ack_reg) begin
      unique case (i_avs_address)
        ecu_pkg::ADDR_CAPTURE_CTRL:  readdata_reg <= {28'h0000000, capture_control_reg};
        ecu_pkg::ADDR_RESULT_LOW:    readdata_reg <= {24'h000000, capture_result_reg[7:0]};
        ecu_pkg::ADDR_RESULT_HIGH:   readdata_reg <= {24'h000000, capture_result_reg[15:8]};
        ecu_pkg::ADDR_TB_COUNT_LOW:  readdata_reg <= {24'h000000, timebase_count[7:0]};
        ecu_pkg::ADDR_TB_COUNT_HIGH: readdata_reg <= {24'h000000, timebase_count[15:8]};
        ecu_pkg::ADDR_TB_CTRL:       readdata_reg <= {30'h00000000, tb_ctrl_reg};
        ecu_pkg::ADDR_FLAG:          readdata_reg <= {31'h00000000, capture_event_flag_reg};
        ecu_pkg::ADDR_IRQ_STATUS:    readdata_reg <= {30'h00000000, irq_status_reg};
        ecu_pkg::ADDR_IRQ_MASK:      readdata_reg <= {30'h00000000, irq_mask_reg};
        default:                     readdata_reg <= 32'h00000000;
      endcase
    end
  end

  assign o_avs_readdata = readdata_reg;

  // Software control registers
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      capture_control_reg <= ecu_pkg::CAPTURE_CTRL_RESET;
      tb_ctrl_reg         <= ecu_pkg::TB_CTRL_RESET;
      irq_mask_reg        <= ecu_pkg::IRQ_MASK_RESET;
    end else begin
      if (wr_capture_ctrl) begin
        capture_control_reg <= i_avs_writedata[3:0];
      end
      if (wr_tb_ctrl) begin
        tb_ctrl_reg <= i_avs_writedata[1:0];
      end
      if (wr_irq_mask) begin
        irq_mask_reg <= i_avs_writedata[1:0];
      end
    end
  end

  // Pin and external clock both cross into this domain
  ecu_pin_sync u_pin_sync (
    .i_clock    (i_clock),
    .i_resetn   (i_resetn),
    .i_clock_en (i_clock_en),
    .i_async    (i_capture_pin),
    .o_level    (pin_level)
  );

  ecu_pin_sync u_ext_sync (
    .i_clock    (i_clock),
    .i_resetn   (i_resetn),
    .i_clock_en (i_clock_en),
    .i_async    (i_timebase_ext_clock),
    .o_level    (ext_level)
  );

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      pin_level_reg <= 1'b0;
      ext_level_reg <= 1'b0;
    end else if (i_clock_en) begin
      pin_level_reg <= pin_level;
      ext_level_reg <= ext_level;
    end
  end

  // Pin level is what the pad sees, whoever drives it
  assign pin_rise = pin_level & ~pin_level_reg;
  assign pin_fall = ~pin_level & pin_level_reg;
  assign ext_rise = ext_level & ~ext_level_reg;

  // Instruction clock tick, stopped during sleep
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      instr_div_reg <= ecu_pkg::INSTR_DIV_RESET;
    end else if (i_clock_en && !i_sleep) begin
      instr_div_reg <= instr_div_reg + 2'h1;
    end
  end

  // Divider halts too, so wake-up resumes in the same phase
  assign instr_tick = (instr_div_reg == ecu_pkg::INSTR_DIV_LAST) & ~i_sleep;

  // External source keeps counting in sleep; internal holds its value
  assign tb_advance = tb_ctrl_reg[ecu_pkg::TB_CTRL_RUN_BIT] &
                      (tb_ctrl_reg[ecu_pkg::TB_CTRL_EXT_BIT] ? ext_rise : instr_tick);

  ecu_timebase u_timebase (
    .i_clock      (i_clock),
    .i_resetn     (i_resetn),
    .i_clock_en   (i_clock_en),
    .i_advance    (tb_advance),
    .i_write_low  (wr_count_low),
    .i_write_high (wr_count_high),
    .i_write_data (i_avs_writedata[7:0]),
    .o_count      (timebase_count)
  );

  // Capture modes and event qualification
  assign in_capture_mode = (capture_control_reg == ecu_pkg::MODE_FALL_EVERY) ||
                           (capture_control_reg == ecu_pkg::MODE_RISE_EVERY) ||
                           (capture_control_reg == ecu_pkg::MODE_RISE_DIV4)  ||
                           (capture_control_reg == ecu_pkg::MODE_RISE_DIV16);

  // In sleep only an externally clocked timebase gives meaningful counts
  assign capture_allowed = ~i_sleep | tb_ctrl_reg[ecu_pkg::TB_CTRL_EXT_BIT];

  // Terminal test uses >=, so a leftover count from a larger prescale fires early
  assign prescale_event =
    ((capture_control_reg == ecu_pkg::MODE_RISE_DIV4) &&
     (prescale_reg >= ecu_pkg::PRESCALE_LAST4)) ||
    ((capture_control_reg == ecu_pkg::MODE_RISE_DIV16) &&
     (prescale_reg >= ecu_pkg::PRESCALE_LAST16));

  always_comb begin
    capture_now = 1'b0;
    if (capture_allowed) begin
      if (capture_control_reg == ecu_pkg::MODE_FALL_EVERY) begin
        capture_now = pin_fall;
      end else if (capture_control_reg == ecu_pkg::MODE_RISE_EVERY) begin
        capture_now = pin_rise;
      end else if ((capture_control_reg == ecu_pkg::MODE_RISE_DIV4) ||
                   (capture_control_reg == ecu_pkg::MODE_RISE_DIV16)) begin
        capture_now = pin_rise & prescale_event;
      end
    end
  end

  // Prescaler: async reset clears it, off or non-capture holds it clear
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      prescale_reg <= ecu_pkg::PRESCALE_RESET;
    end else if (i_clock_en) begin
      if (!in_capture_mode) begin
        prescale_reg <= ecu_pkg::PRESCALE_RESET;
      end else if (capture_allowed && pin_rise &&
                   ((capture_control_reg == ecu_pkg::MODE_RISE_DIV4) ||
                    (capture_control_reg == ecu_pkg::MODE_RISE_DIV16))) begin
        prescale_reg <= prescale_event ? 4'h0 : prescale_reg + 4'h1;
      end
    end
  end

  // Whole 16-bit count latched in one edge; no overrun guard
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      capture_result_reg <= ecu_pkg::COUNT_RESET;
    end else if (i_clock_en && capture_now) begin
      capture_result_reg <= timebase_count;
    end
  end

  // Unread tracking: a read of the high byte marks the pair consumed
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      unread_reg <= 1'b0;
    end else if (i_clock_en) begin
      if (capture_now) begin
        unread_reg <= 1'b1;
      end else if (rd_result_high) begin
        unread_reg <= 1'b0;
      end
    end
  end

  // Event flag: set wins over a software clear in the same cycle
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      capture_event_flag_reg <= 1'b0;
    end else if (i_clock_en) begin
      if (capture_now) begin
        capture_event_flag_reg <= 1'b1;
      end else if (wr_flag_clear) begin
        capture_event_flag_reg <= 1'b0;
      end
    end
  end

  // Interrupt status: sticky, cleared by reading it, set beats clear
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_status_reg <= ecu_pkg::IRQ_STATUS_RESET;
    end else if (i_clock_en) begin
      if (rd_irq_status) begin
        irq_status_reg <= ecu_pkg::IRQ_STATUS_RESET;
      end
      if (capture_now) begin
        irq_status_reg[ecu_pkg::IRQ_CAPTURE_BIT] <= 1'b1;
      end
      if (capture_now && unread_reg) begin
        irq_status_reg[ecu_pkg::IRQ_OVERRUN_BIT] <= 1'b1;
      end
    end
  end

  assign o_irq = |(irq_status_reg & irq_mask_reg);

endmodule
`default_nettype wire

// File: pkg/ecu_pkg.sv
package ecu_pkg;

  // Avalon-MM byte offsets, one 32-bit word per register
  localparam logic [5:0] ADDR_CAPTURE_CTRL  = 6'h00;
  localparam logic [5:0] ADDR_RESULT_LOW    = 6'h04;
  localparam logic [5:0] ADDR_RESULT_HIGH   = 6'h08;
  localparam logic [5:0] ADDR_TB_COUNT_LOW  = 6'h0C;
  localparam logic [5:0] ADDR_TB_COUNT_HIGH = 6'h10;
  localparam logic [5:0] ADDR_TB_CTRL       = 6'h14;
  localparam logic [5:0] ADDR_FLAG          = 6'h18;
  localparam logic [5:0] ADDR_IRQ_STATUS    = 6'h1C;
  localparam logic [5:0] ADDR_IRQ_MASK      = 6'h20;

  // Capture mode select encodings
  localparam logic [3:0] MODE_OFF        = 4'h0;
  localparam logic [3:0] MODE_FALL_EVERY = 4'h4;
  localparam logic [3:0] MODE_RISE_EVERY = 4'h5;
  localparam logic [3:0] MODE_RISE_DIV4  = 4'h6;
  localparam logic [3:0] MODE_RISE_DIV16 = 4'h7;

  // Prescaler terminal counts
  localparam logic [3:0] PRESCALE_LAST4  = 4'h3;
  localparam logic [3:0] PRESCALE_LAST16 = 4'hF;

  // Field positions
  localparam int TB_CTRL_RUN_BIT  = 0;
  localparam int TB_CTRL_EXT_BIT  = 1;
  localparam int FLAG_CAPTURE_BIT = 0;
  localparam int IRQ_CAPTURE_BIT  = 0;
  localparam int IRQ_OVERRUN_BIT  = 1;

  // Reset values
  localparam logic [3:0] CAPTURE_CTRL_RESET = 4'h0;
  localparam logic [1:0] TB_CTRL_RESET      = 2'h0;
  localparam logic [1:0] IRQ_MASK_RESET     = 2'h0;
  localparam logic [1:0] IRQ_STATUS_RESET   = 2'h0;
  localparam logic [3:0] PRESCALE_RESET     = 4'h0;
  localparam logic [1:0] INSTR_DIV_RESET    = 2'h0;
  localparam logic [15:0] COUNT_RESET       = 16'h0000;

  // Instruction clock is the system clock divided by this
  localparam int          INSTR_DIVIDE   = 4;
  localparam logic [1:0]  INSTR_DIV_LAST = 2'(INSTR_DIVIDE - 1);

endpackage

// File: logic/ecu_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ecu_pin_sync (
  // Clock and reset
  input  wire logic i_clock,
  input  wire logic i_resetn,
  input  wire logic i_clock_en,
  // Asynchronous level in, filtered level out
  input  wire logic i_async,
  output logic      o_level
);

  logic stage1_reg;
  logic stage2_reg;
  logic stage3_reg;
  logic level_reg;

  // First stage feeds only the second one
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      stage1_reg <= 1'b0;
      stage2_reg <= 1'b0;
      stage3_reg <= 1'b0;
    end else if (i_clock_en) begin
      stage1_reg <= i_async;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // Accept a change only when the last two stages agree
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      level_reg <= 1'b0;
    end else if (i_clock_en && (stage2_reg == stage3_reg)) begin
      level_reg <= stage3_reg;
    end
  end

  assign o_level = level_reg;

endmodule
`default_nettype wire

// File: logic/ecu_timebase.sv
`timescale 1ns/1ps
`default_nettype none
module ecu_timebase (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_resetn,
  input  wire logic        i_clock_en,
  // Count control
  input  wire logic        i_advance,
  input  wire logic        i_write_low,
  input  wire logic        i_write_high,
  input  wire logic [7:0]  i_write_data,
  // Count value
  output logic      [15:0] o_count
);

  logic [15:0] count_reg;
  logic [15:0] count_next;

  // Software write takes priority over a count step
  always_comb begin
    count_next = count_reg;
    if (i_advance) begin
      count_next = count_reg + 16'h0001;
    end
    if (i_write_low) begin
      count_next[7:0] = i_write_data;
    end
    if (i_write_high) begin
      count_next[15:8] = i_write_data;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      count_reg <= ecu_pkg::COUNT_RESET;
    end else if (i_clock_en) begin
      count_reg <= count_next;
    end
  end

  assign o_count = count_reg;

endmodule
`default_nettype wire

// File: tb/ecu_edge_capture_unit_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module ecu_checker (
  // Clock and reset
  input wire logic        i_clock,
  input wire logic        i_resetn,
  input wire logic        i_clock_en,
  // Bus
  input wire logic [5:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [3:0]  i_avs_byteenable,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  // Pins and interrupt
  input wire logic        i_capture_pin,
  input wire logic        i_timebase_ext_clock,
  input wire logic        i_sleep,
  input wire logic        o_irq
);
  logic       req;
  logic       done;
  logic       touch;
  logic       pin_prev_reg;
  logic [3:0] pin_age_reg;
  assign req   = i_avs_read | i_avs_write;
  assign done  = req & ~o_avs_waitrequest & i_clock_en;
  assign touch = done & ((i_avs_write & i_avs_byteenable[0]
                 & (i_avs_address == ecu_pkg::ADDR_IRQ_MASK))
                 | (i_avs_read & (i_avs_address == ecu_pkg::ADDR_IRQ_STATUS)));
  // Saturates so a quiet pin never wraps back into the window
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      pin_prev_reg <= 1'b0;
      pin_age_reg  <= 4'hF;
    end else begin
      pin_prev_reg <= i_capture_pin;
      pin_age_reg  <= (i_capture_pin != pin_prev_reg) ? 4'h0
                      : pin_age_reg + {3'h0, pin_age_reg != 4'hF};
    end
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  AST_WAIT_FIRST: assert property ($rose(req) |-> o_avs_waitrequest)
    else $error("new request without wait state");
  AST_WAIT_ONE: assert property (req && o_avs_waitrequest && i_clock_en |=> !o_avs_waitrequest)
    else $error("wait state longer than one cycle");
  AST_IDLE_NOWAIT: assert property (!req |-> !o_avs_waitrequest)
    else $error("waitrequest while idle");
  AST_UPPER_ZERO: assert property (o_avs_readdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  AST_RESET_OUT: assert property ($rose(i_resetn) |-> !o_irq && o_avs_readdata == 32'h0)
    else $error("outputs not clear after reset");
  AST_IRQ_FALL: assert property ($fell(o_irq) |-> $past(touch))
    else $error("interrupt dropped without software action");
  AST_IRQ_RISE: assert property ($rose(o_irq) |-> $past(touch) || pin_age_reg <= 4'h9)
    else $error("interrupt rose without pin edge");
  AST_READ_STANDS: assert property (!(i_avs_read && o_avs_waitrequest && i_clock_en)
    |=> $stable(o_avs_readdata))
    else $error("read data moved outside a read");
endmodule
bind ecu_edge_capture_unit ecu_checker u_chk (
  .i_clock(i_clock), .i_resetn(i_resetn), .i_clock_en(i_clock_en),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_avs_byteenable(i_avs_byteenable), .i_avs_writedata(i_avs_writedata),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .i_capture_pin(i_capture_pin), .i_timebase_ext_clock(i_timebase_ext_clock),
  .i_sleep(i_sleep), .o_irq(o_irq));
`default_nettype wire

// File: tb/ecu_pin_source.sv
`timescale 1ns/1ps
`default_nettype none
module ecu_pin_source (
  // Clock and control
  input  wire logic       i_clock,
  input  wire logic       i_start,
  input  wire logic       i_slow,
  input  wire logic       i_ext_en,
  input  wire logic [4:0] i_count,
  // Pin side
  output logic            o_pin,
  output logic            o_ext_clock,
  output logic            o_busy
);
  logic [4:0] left = 5'h00;
  logic [3:0] tick = 4'h0;
  logic [1:0] div = 2'h0;
  initial o_pin = 1'b0;
  initial o_ext_clock = 1'b0;
  assign o_busy = (left != 5'h00);
  // Pin driven as a plain input level, held at least four clocks
  always @(posedge i_clock) begin
    if (i_start) begin
      left <= i_count;
      tick <= 4'h0;
    end else if (left != 5'h00) begin
      tick <= tick + 4'h1;
      if (tick == (i_slow ? 4'h9 : 4'h3)) begin
        tick  <= 4'h0;
        o_pin <= !o_pin;
        if (o_pin) left <= left - 5'h01;
      end
    end
  end
  // External clock well below system rate; still when disabled
  always @(posedge i_clock) begin
    if (i_ext_en) begin
      div <= div + 2'h1;
      if (div == 2'h2) begin
        div         <= 2'h0;
        o_ext_clock <= !o_ext_clock;
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        avs_rd = 1'b0;
  logic        avs_wr = 1'b0;
  logic [5:0]  addr = 6'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  be = 4'hF;
  logic        sleep = 1'b0;
  logic        clk_en = 1'b1;
  logic        start = 1'b0;
  logic        slow = 1'b0;
  logic        ext_en = 1'b0;
  logic [4:0]  cnt = 5'h00;
  logic [31:0] rdata;
  logic        waitreq;
  logic        irq;
  logic        pin;
  logic        ext_clk;
  logic        busy;
  logic [7:0]  q;
  logic [3:0]  modes [4];
  logic [4:0]  need [4];
  int          err_total = 0;
  int          check_count = 0;
  int          cycles = 0;
  initial begin
    forever #25 clk = ~clk;
  end
  ecu_edge_capture_unit dut (
    .i_clock(clk), .i_resetn(rstn), .i_clock_en(clk_en), .i_avs_address(addr),
    .i_avs_read(avs_rd), .i_avs_write(avs_wr), .i_avs_byteenable(be),
    .i_avs_writedata(wdata), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
    .i_capture_pin(pin), .i_timebase_ext_clock(ext_clk), .i_sleep(sleep), .o_irq(irq));
  ecu_pin_source src (
    .i_clock(clk), .i_start(start), .i_slow(slow), .i_ext_en(ext_en), .i_count(cnt),
    .o_pin(pin), .o_ext_clock(ext_clk), .o_busy(busy));
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Holds the request until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    avs_rd <= !w;
    avs_wr <= w;
    addr <= a;
    wdata <= {24'h0, d};
    do begin
      @(posedge clk);
    end while (waitreq !== 1'b0);
    q = rdata[7:0];
    avs_rd <= 1'b0;
    avs_wr <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] m, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q & m, e);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic flag(input logic [7:0] e);
    rd(ecu_pkg::ADDR_FLAG, 8'h01, e);
  endtask
  task automatic pulses(input logic [4:0] n);
    cnt <= n;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    do @(posedge clk); while (busy);
    repeat (8) @(posedge clk);
  endtask
  task automatic setmode(input logic [3:0] m);
    wr(ecu_pkg::ADDR_CAPTURE_CTRL, 8'h00);
    wr(ecu_pkg::ADDR_CAPTURE_CTRL, {4'h0, m});
    wr(ecu_pkg::ADDR_FLAG, 8'h00);
  endtask
  task automatic setcnt(input logic [15:0] v);
    wr(ecu_pkg::ADDR_TB_COUNT_LOW, v[7:0]);
    wr(ecu_pkg::ADDR_TB_COUNT_HIGH, v[15:8]);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      err_total++;
      close_out();
    end
  end
  initial begin
    modes = '{ecu_pkg::MODE_FALL_EVERY, ecu_pkg::MODE_RISE_EVERY,
              ecu_pkg::MODE_RISE_DIV4, ecu_pkg::MODE_RISE_DIV16};
    need = '{5'd1, 5'd1, 5'd4, 5'd16};
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rd(ecu_pkg::ADDR_CAPTURE_CTRL, 8'hFF, 8'h00);
    rd(ecu_pkg::ADDR_TB_CTRL, 8'hFF, 8'h00);
    rd(ecu_pkg::ADDR_IRQ_MASK, 8'hFF, 8'h00);
    rd(ecu_pkg::ADDR_RESULT_HIGH, 8'hFF, 8'h00);
    wr(6'h24, 8'hFF);
    rd(6'h24, 8'hFF, 8'h00);
    be <= 4'h0;
    wr(ecu_pkg::ADDR_CAPTURE_CTRL, 8'h05);
    be <= 4'hF;
    rd(ecu_pkg::ADDR_CAPTURE_CTRL, 8'hFF, 8'h00);
    // Timebase stopped, so every capture value is known
    for (int i = 0; i < 4; i++) begin
      setmode(modes[i]);
      setcnt({4'hA, 4'(i), 4'h3, 4'(i)});
      pulses(need[i] - 5'd1);
      flag(8'h00);
      pulses(5'd1);
      flag(8'h01);
      rd(ecu_pkg::ADDR_RESULT_LOW, 8'hFF, {4'h3, 4'(i)});
      rd(ecu_pkg::ADDR_RESULT_HIGH, 8'hFF, {4'hA, 4'(i)});
    end
    wr(ecu_pkg::ADDR_FLAG, 8'h01);
    flag(8'h01);
    setmode(ecu_pkg::MODE_RISE_EVERY);
    setcnt(16'h1234);
    pulses(5'd1);
    setcnt(16'h5678);
    slow <= 1'b1;
    pulses(5'd1);
    slow <= 1'b0;
    rd(ecu_pkg::ADDR_RESULT_LOW, 8'hFF, 8'h78);
    rd(ecu_pkg::ADDR_RESULT_HIGH, 8'hFF, 8'h56);
    setmode(ecu_pkg::MODE_RISE_DIV16);
    pulses(5'd5);
    wr(ecu_pkg::ADDR_CAPTURE_CTRL, {4'h0, ecu_pkg::MODE_RISE_DIV4});
    wr(ecu_pkg::ADDR_FLAG, 8'h00);
    pulses(5'd1);
    flag(8'h01);
    setmode(ecu_pkg::MODE_RISE_DIV4);
    pulses(5'd2);
    setmode(ecu_pkg::MODE_RISE_DIV4);
    pulses(5'd2);
    flag(8'h00);
    pulses(5'd2);
    flag(8'h01);
    setmode(ecu_pkg::MODE_RISE_EVERY);
    bus(1'b0, ecu_pkg::ADDR_IRQ_STATUS, 8'h00);
    wr(ecu_pkg::ADDR_IRQ_MASK, 8'h01);
    pulses(5'd1);
    chk({7'h0, irq}, 8'h01);
    rd(ecu_pkg::ADDR_IRQ_STATUS, 8'h01, 8'h01);
    @(posedge clk);
    chk({7'h0, irq}, 8'h00);
    wr(ecu_pkg::ADDR_IRQ_MASK, 8'h00);
    pulses(5'd1);
    chk({7'h0, irq}, 8'h00);
    rd(ecu_pkg::ADDR_IRQ_STATUS, 8'h01, 8'h01);
    setcnt(16'h0040);
    sleep <= 1'b1;
    wr(ecu_pkg::ADDR_TB_CTRL, 8'h01);
    repeat (40) @(posedge clk);
    rd(ecu_pkg::ADDR_TB_COUNT_LOW, 8'hFF, 8'h40);
    sleep <= 1'b0;
    repeat (40) @(posedge clk);
    bus(1'b0, ecu_pkg::ADDR_TB_COUNT_LOW, 8'h00);
    chk({7'h0, q > 8'h40}, 8'h01);
    wr(ecu_pkg::ADDR_FLAG, 8'h00);
    sleep <= 1'b1;
    pulses(5'd1);
    flag(8'h00);
    wr(ecu_pkg::ADDR_TB_CTRL, 8'h03);
    ext_en <= 1'b1;
    pulses(5'd1);
    flag(8'h01);
    sleep <= 1'b0;
    // Clock enable low freezes the filter, so a pulse goes unseen
    wr(ecu_pkg::ADDR_FLAG, 8'h00);
    clk_en <= 1'b0;
    pulses(5'd1);
    clk_en <= 1'b1;
    flag(8'h00);
    pulses(5'd1);
    flag(8'h01);
    close_out();
  end
endmodule
`default_nettype wire
